// file: hdl/aig_agen.sv
// auxiliary-pointer indirect address generator and pointer file
// assumes: requests come from the decoder on mclk, no synchroniser
`timescale 1ns/1ps
`default_nettype none
module aig_agen #(
  parameter int unsigned NPTR = aig_pkg::NUM_PTR // pointer count
) (
  input  wire logic              mclk,              // cpu clock
  input  wire logic              reset_n,           // async reset
  input  wire logic              req_valid,         // operand request
  input  wire aig_pkg::aig_req_s req,               // operand fields
  input  wire logic              load_valid,        // pointer write
  input  wire aig_pkg::aig_load_s load,             // write fields
  input  wire logic              operand_set_select, // 1: control set
  input  wire logic              legacy_compat_bit, // index source
  input  wire logic [7:0]        circ_cfg,          // circular per ptr
  input  wire logic [15:0]       temp_reg_zero,     // index value
  input  wire logic [15:0]       circ_buffer_start_pair_a, // ptr 0/1
  input  wire logic [15:0]       circ_buffer_start_pair_b, // ptr 2/3
  input  wire logic [15:0]       circ_buffer_start_pair_c, // ptr 4/5
  input  wire logic [15:0]       circ_buffer_start_pair_d, // ptr 6/7
  input  wire logic [63:0]       circ_size,         // 4 x 16 sizes
  input  wire logic              bit_op_legal,      // bit instr, target
  input  wire logic              bit_target_wide,   // 40-bit target
  input  wire logic [2:0]        rd_sel,            // pointer readout
  output logic      [22:0]       rd_ptr,            // selected pointer
  output logic                   out_valid,         // address pulse
  output logic      [22:0]       out_addr,          // data address
  output logic      [15:0]       out_io_addr,       // io address
  output logic      [5:0]        out_bit_num,       // bit number
  output logic                   out_refused,       // refused pulse
  output logic                   out_bit_range_err  // bit beyond max
);

  // ***********************************************************
  // state
  // ***********************************************************
  logic [22:0] xar_q [NPTR];
  logic        out_valid_q;
  logic [22:0] out_addr_q;
  logic [15:0] out_io_q;
  logic [5:0]  out_bit_q;
  logic        refused_q;
  logic        range_err_q;
  logic [2:0]  sel_q;

  logic [22:0] cur_ptr;
  logic [22:0] idx_ext;
  logic [22:0] step;
  logic [22:0] delta;
  logic [22:0] next_ptr;
  logic [22:0] eff_ptr;
  logic [22:0] addr_calc;
  logic [15:0] bsa;
  logic [15:0] size_sel;
  logic        circ;
  logic        ctrl_ok;
  logic        refuse;
  logic        take;
  logic        writes;
  logic [5:0]  bit_max;
  logic        bit_over;

  // ***********************************************************
  // operand decode
  // ***********************************************************
  assign cur_ptr  = xar_q[req.ptr];
  assign circ     = circ_cfg[req.ptr];
  assign size_sel = circ_size[{req.ptr[2:1], 4'h0} +: 16];

  // buffer start follows the pointer pair
  always_comb begin
    bsa = circ_buffer_start_pair_a;
    if (req.ptr[2:1] == 2'b01) begin
      bsa = circ_buffer_start_pair_b;
    end else if (req.ptr[2:1] == 2'b10) begin
      bsa = circ_buffer_start_pair_c;
    end else if (req.ptr[2:1] == 2'b11) begin
      bsa = circ_buffer_start_pair_d;
    end
  end

  // index source: sign-extended temp zero or extended pointer zero
  assign idx_ext = legacy_compat_bit ? xar_q[0]
                 : {{7{temp_reg_zero[15]}}, temp_reg_zero};

  assign step = req.wide ? aig_pkg::STEP_TWO
                         : aig_pkg::STEP_ONE;

  // step direction and size per operand
  always_comb begin
    delta = 23'h00_0000;
    case (req.op)
      aig_pkg::AIG_OP_POST_INC,
      aig_pkg::AIG_OP_PRE_INC: begin
        delta = step;
      end
      aig_pkg::AIG_OP_POST_DEC,
      aig_pkg::AIG_OP_PRE_DEC: begin
        delta = 23'h00_0000 - step;
      end
      aig_pkg::AIG_OP_POST_ADD,
      aig_pkg::AIG_OP_BASE_IDX: begin
        delta = idx_ext;
      end
      aig_pkg::AIG_OP_POST_SUB: begin
        delta = 23'h00_0000 - idx_ext;
      end
      default: begin
        delta = 23'h00_0000;
      end
    endcase
  end

  aig_ptr_step u_step (
    .ptr      (cur_ptr),
    .delta    (delta),
    .circ     (circ),
    .size     (size_sel),
    .next_ptr (next_ptr)
  );

  // pre operands and base-index address from the modified value;
  // post operands address from the value before the step
  always_comb begin
    eff_ptr = cur_ptr;
    case (req.op)
      aig_pkg::AIG_OP_PRE_INC,
      aig_pkg::AIG_OP_PRE_DEC,
      aig_pkg::AIG_OP_BASE_IDX: begin
        eff_ptr = next_ptr;
      end
      default: begin
        eff_ptr = cur_ptr;
      end
    endcase
  end

  // address is the extended pointer, or high page plus buffer
  // start plus low part; carry above 23 bits is left to software
  assign addr_calc = circ
    ? {eff_ptr[22:16], 16'h0000} + {7'h00, bsa}
      + {7'h00, eff_ptr[15:0]}
    : eff_ptr;

  // control set keeps only the three common operands here
  assign ctrl_ok = (req.op == aig_pkg::AIG_OP_PLAIN)
                || (req.op == aig_pkg::AIG_OP_POST_INC)
                || (req.op == aig_pkg::AIG_OP_POST_DEC);
  assign refuse  = (operand_set_select && !ctrl_ok)
                || (req.acc == aig_pkg::AIG_ACC_BIT
                    && !bit_op_legal);
  assign take    = req_valid && !refuse;
  assign writes  = take && (req.op != aig_pkg::AIG_OP_PLAIN)
                        && (req.op != aig_pkg::AIG_OP_BASE_IDX);

  assign bit_max  = bit_target_wide ? aig_pkg::BIT_MAX_WIDE
                                    : aig_pkg::BIT_MAX_NARR;
  assign bit_over = (eff_ptr[15:6] != 10'h000)
                 || (eff_ptr[5:0] > bit_max);

  // ***********************************************************
  // pointer file
  // ***********************************************************
  // a load to the pointer being stepped wins on the bits it writes: software intent
  // is taken over an in-flight step in the same cycle; a low-part load keeps the stepped high part
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NPTR; i++) begin
        xar_q[i] <= aig_pkg::XAR_RST;
      end
    end else begin
      if (writes) begin
        xar_q[req.ptr] <= next_ptr;
      end
      if (load_valid) begin
        if (load.full) begin
          xar_q[load.ptr] <= load.data;
        end else begin
          xar_q[load.ptr][15:0] <= load.data[15:0];
        end
      end
    end
  end

  // ***********************************************************
  // result registers
  // ***********************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_q <= 1'b0;
      refused_q   <= 1'b0;
      range_err_q <= 1'b0;
      sel_q       <= 3'h0;
    end else begin
      out_valid_q <= take;
      refused_q   <= req_valid && refuse;
      range_err_q <= take && (req.acc == aig_pkg::AIG_ACC_BIT)
                          && bit_over;
      sel_q       <= req.ptr;
    end
  end

  // io address is the low 16 bits; a step past the ends wraps
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_addr_q <= 23'h00_0000;
      out_io_q   <= 16'h0000;
      out_bit_q  <= 6'h00;
    end else if (take) begin
      out_addr_q <= addr_calc;
      out_io_q   <= addr_calc[15:0];
      out_bit_q  <= eff_ptr[5:0];
    end
  end

  assign rd_ptr            = xar_q[rd_sel];
  assign out_valid         = out_valid_q;
  assign out_addr          = out_addr_q;
  assign out_io_addr       = out_io_q;
  assign out_bit_num       = out_bit_q;
  assign out_refused       = refused_q;
  assign out_bit_range_err = range_err_q;

  // ***********************************************************
  // checks
  // ***********************************************************
  logic [22:0] ptr_now;
  assign ptr_now = xar_q[sel_q];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  AST_IO_ADDR: assert property (
    take && !circ && req.acc == aig_pkg::AIG_ACC_IO
    |=> out_valid && out_io_addr == $past(eff_ptr[15:0]))
    else $error("io address not the pointer low part");
  AST_SET_REFUSE: assert property (
    req_valid && operand_set_select
    && req.op == aig_pkg::AIG_OP_PRE_INC
    |=> out_refused && !out_valid)
    else $error("control set accepted a signal-only operand");
  AST_CIRC_ADDR: assert property (
    take && circ |=> out_addr[15:0]
      == $past(bsa) + $past(eff_ptr[15:0]))
    else $error("circular address lacks buffer start");
  AST_PLAIN_KEEP: assert property (
    take && req.op == aig_pkg::AIG_OP_PLAIN && !load_valid
    |=> ptr_now == $past(cur_ptr))
    else $error("plain operand changed the pointer");
  AST_POST_INC: assert property (
    take && req.op == aig_pkg::AIG_OP_POST_INC && !circ
    && !req.wide && !load_valid
    |=> out_addr == $past(cur_ptr) && ptr_now == out_addr + 23'h1)
    else $error("post-increment order or step wrong");
  AST_POST_DEC: assert property (
    take && req.op == aig_pkg::AIG_OP_POST_DEC && !circ
    && req.wide && !load_valid
    |=> out_addr == $past(cur_ptr) && ptr_now == out_addr - 23'h2)
    else $error("post-decrement order or step wrong");
  AST_PRE_INC: assert property (
    take && req.op == aig_pkg::AIG_OP_PRE_INC && !circ
    && req.wide && !load_valid
    |=> out_addr == ptr_now && ptr_now == $past(cur_ptr) + 23'h2)
    else $error("pre-increment order or step wrong");
  AST_PRE_DEC: assert property (
    take && req.op == aig_pkg::AIG_OP_PRE_DEC && !circ
    && !req.wide && !load_valid
    |=> out_addr == ptr_now && ptr_now == $past(cur_ptr) - 23'h1)
    else $error("pre-decrement order or step wrong");
  AST_PAGE_CROSS: assert property (
    take && req.op == aig_pkg::AIG_OP_POST_INC && !circ
    && !req.wide && !load_valid && cur_ptr[15:0] == 16'hFFFF
    |=> ptr_now == {$past(cur_ptr[22:16]) + 7'h01, 16'h0000})
    else $error("step did not cross the page");
  AST_INDEX_ADD: assert property (
    take && req.op == aig_pkg::AIG_OP_POST_ADD && !circ
    && !legacy_compat_bit && !load_valid
    |=> ptr_now == $past(cur_ptr)
      + {{7{$past(temp_reg_zero[15])}}, $past(temp_reg_zero)})
    else $error("index add wrong");
  AST_INDEX_SRC: assert property (
    take && req.op == aig_pkg::AIG_OP_BASE_IDX && !circ
    && legacy_compat_bit
    |=> out_addr == $past(cur_ptr) + $past(xar_q[0]))
    else $error("index not taken from pointer zero");
  AST_BIT_RANGE: assert property (
    take && req.acc == aig_pkg::AIG_ACC_BIT && !bit_target_wide
    && eff_ptr[15:0] == 16'h0010 |=> out_bit_range_err)
    else $error("bit number 16 accepted on narrow target");
  AST_BIT_LEGAL: assert property (
    req_valid && req.acc == aig_pkg::AIG_ACC_BIT && !bit_op_legal
    && !load_valid |=> out_refused ##0 ptr_now == $past(cur_ptr))
    else $error("illegal bit access modified the pointer");

  COV_POST_INC: cover property (
    take && req.op == aig_pkg::AIG_OP_POST_INC ##1 take);
  COV_CIRC: cover property (take && circ
    && req.op == aig_pkg::AIG_OP_PRE_DEC);
  COV_IO: cover property (take && req.acc == aig_pkg::AIG_ACC_IO);
  COV_REFUSE: cover property (out_refused);

endmodule
`default_nettype wire

// file: hdl/aig_pkg.sv
// package for the auxiliary-pointer indirect address generator
// assumes: one clock, used by aig_agen, aig_dec_model and the bench
package aig_pkg;

  // ***********************************************************
  // widths and reset values
  // ***********************************************************
  localparam int unsigned ADDR_W  = 23; // extended pointer width
  localparam int unsigned LOW_W   = 16; // low pointer / io width
  localparam int unsigned HIGH_W  = 7;  // high extension width
  localparam int unsigned NUM_PTR = 8;  // extended pointers
  localparam int unsigned BIT_W   = 6;  // bit number width

  localparam logic [22:0] XAR_RST      = 23'h00_0000;
  localparam logic [5:0]  BIT_MAX_WIDE = 6'h27; // 40-bit target
  localparam logic [5:0]  BIT_MAX_NARR = 6'h0F; // 16-bit target
  localparam logic [22:0] STEP_ONE     = 23'h00_0001;
  localparam logic [22:0] STEP_TWO     = 23'h00_0002;

  // ***********************************************************
  // operands, access kinds and carriers
  // ***********************************************************
  typedef enum logic [2:0] {
    AIG_OP_PLAIN    = 3'b000, // pointer unchanged
    AIG_OP_POST_INC = 3'b001,
    AIG_OP_POST_DEC = 3'b010,
    AIG_OP_PRE_INC  = 3'b011,
    AIG_OP_PRE_DEC  = 3'b100,
    AIG_OP_POST_ADD = 3'b101, // add index after address
    AIG_OP_POST_SUB = 3'b110, // subtract index after address
    AIG_OP_BASE_IDX = 3'b111  // base plus index, no update
  } aig_op_e;

  typedef enum logic [1:0] {
    AIG_ACC_DATA = 2'b00,
    AIG_ACC_BIT  = 2'b01,
    AIG_ACC_IO   = 2'b10
  } aig_acc_e;

  typedef struct packed {
    aig_op_e     op;
    aig_acc_e    acc;
    logic        wide;  // 32-bit word or bit pair
    logic [2:0]  ptr;
  } aig_req_s;

  typedef struct packed {
    logic        full;  // 1: whole extended pointer, 0: low part
    logic [2:0]  ptr;
    logic [22:0] data;
  } aig_load_s;

endpackage

// file: hdl/aig_ptr_step.sv
// pointer step: linear 23-bit or circular modification
// assumes: the step magnitude is below the circular buffer size
`timescale 1ns/1ps
`default_nettype none
module aig_ptr_step (
  input  wire logic [22:0] ptr,      // current extended pointer
  input  wire logic [22:0] delta,    // two's complement step
  input  wire logic        circ,     // circular mode for pointer
  input  wire logic [15:0] size,     // circular buffer size
  output logic      [22:0] next_ptr  // modified pointer
);

  logic [22:0] lin_sum;
  logic [17:0] lo_sum;
  logic [17:0] lo_wrap;

  // linear steps use full 23-bit width so pages are crossed
  assign lin_sum = ptr + delta;
  assign lo_sum  = {2'b00, ptr[15:0]} + delta[17:0];

  // circular wrap keeps the low part inside the buffer
  always_comb begin
    lo_wrap = lo_sum;
    if (size != 16'h0000) begin
      if (lo_sum[17]) begin
        lo_wrap = lo_sum + {2'b00, size};
      end else if (lo_sum >= {2'b00, size}) begin
        lo_wrap = lo_sum - {2'b00, size};
      end
    end
  end

  // a zero size degenerates to a 64K ring on the low part
  assign next_ptr = circ ? {ptr[22:16], lo_wrap[15:0]}
                         : lin_sum;

endmodule
`default_nettype wire

// file: tb/aig_dec_model.sv
// decoder-side model: operand requests and pointer writes
// assumes: the caller enters just after a rising mclk edge
`timescale 1ns/1ps
`default_nettype none
module aig_dec_model (
  input  wire logic          mclk,       // cpu clock
  output aig_pkg::aig_req_s  req,        // operand fields
  output logic               req_valid,  // operand request
  output aig_pkg::aig_load_s load,       // write fields
  output logic               load_valid  // pointer write
);
  // ******************************************
  // decoder traffic
  // ******************************************
  // idle from time zero
  initial begin
    req_valid  = 1'b0;
    req        = '0;
    load_valid = 1'b0;
    load       = '0;
  end

  // high part kept clear of both ends, wrap there is unsupported
  function automatic aig_pkg::aig_load_s legal(aig_pkg::aig_load_s l);
    l.data[22:16] = 7'h01 + 7'(l.data[22:16] % 7'h7C);
    return l;
  endfunction

  // one cycle: kind 0 idle, 1 request, 2 pointer write
  // the caller passes a load already kept legal, so that its own
  // copy of the pointer file sees exactly what the design gets
  task automatic drive(int k, aig_pkg::aig_req_s r,
                       aig_pkg::aig_load_s l);
    req_valid  <= (k == 1);
    req        <= r;
    load_valid <= (k == 2);
    load       <= l;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_aux_reg_indirect_agen.sv
// self-checking bench for the pointer address generator
// assumes: aig_pkg, aig_agen and aig_dec_model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_aux_reg_indirect_agen;
  typedef struct {
    int v, rf, er, ad, bn, bt;
  } aig_exp_s;
  localparam logic [63:0] SIZES = 64'h0000_0040_0000_0000;
  localparam int          MASK  = 'h7F_FFFF;
  logic               mclk, reset_n, req_valid, load_valid;
  logic               sel, leg, legal, twide;
  logic               out_valid, out_refused, out_bit_range_err;
  aig_pkg::aig_req_s  req;
  aig_pkg::aig_load_s load;
  logic [15:0]        t0, out_io_addr;
  logic [15:0]        bsa [4];
  logic [2:0]         rd_sel;
  logic [22:0]        rd_ptr, out_addr;
  logic [5:0]         out_bit_num;
  int                 failures, n_compared, xar[8], m_bsa[4];
  int                 m_sel, m_leg, m_legal, m_tw, m_t0;
  aig_exp_s           pv, cv;

  // ******************************************
  // design, decoder model, clock
  // ******************************************
  // pointers 4..7 run circular: 64-entry ring and 64K ring
  aig_agen u_dut (
    .mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .load_valid(load_valid), .load(load), .operand_set_select(sel),
    .legacy_compat_bit(leg), .circ_cfg(8'hF0), .temp_reg_zero(t0),
    .circ_buffer_start_pair_a(bsa[0]), .circ_buffer_start_pair_b(bsa[1]),
    .circ_buffer_start_pair_c(bsa[2]), .circ_buffer_start_pair_d(bsa[3]),
    .circ_size(SIZES), .bit_op_legal(legal), .bit_target_wide(twide),
    .rd_sel(rd_sel), .rd_ptr(rd_ptr), .out_valid(out_valid),
    .out_addr(out_addr), .out_io_addr(out_io_addr),
    .out_bit_num(out_bit_num), .out_refused(out_refused),
    .out_bit_range_err(out_bit_range_err));

  aig_dec_model u_dec (
    .mclk(mclk), .req(req), .req_valid(req_valid), .load(load),
    .load_valid(load_valid));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ******************************************
  // compare, verdict, reference model
  // ******************************************
  task automatic chk_val(string nm, logic [22:0] seen, int exp);
    n_compared++;
    if (seen !== 23'(exp)) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, 23'(exp), seen);
    end
  endtask

  task automatic chk_flag(string nm, logic seen, int exp);
    n_compared++;
    if (seen !== 1'(exp)) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0b", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // circular steps stay in the low 16 bits, high part untouched
  function automatic int step(int p, int d, bit c, int sz);
    if (!c) return (p + d) & MASK;
    return (p & 'h7F_0000) | (((p & 'hFFFF) + d + sz) % sz);
  endfunction

  task automatic model(aig_pkg::aig_req_s r);
    int p, e, n, idx, sz;
    bit c;
    cv.rf = (m_sel && r.op > aig_pkg::AIG_OP_POST_DEC) ||
            (r.acc == aig_pkg::AIG_ACC_BIT && !m_legal);
    if (cv.rf) return;
    p   = xar[r.ptr];
    c   = r.ptr[2];
    sz  = int'(SIZES[r.ptr[2:1]*16 +: 16]);
    sz  = (sz == 0) ? 'h1_0000 : sz;
    idx = m_leg ? xar[0] : m_t0;
    n   = r.wide ? 2 : 1;
    case (int'(r.op))
      1: begin e = p; n = step(p, n, c, sz); end
      2: begin e = p; n = step(p, -n, c, sz); end
      3: begin n = step(p, n, c, sz); e = n; end
      4: begin n = step(p, -n, c, sz); e = n; end
      5: begin e = p; n = (p + idx) & MASK; end
      6: begin e = p; n = (p - idx) & MASK; end
      7: begin e = (p + idx) & MASK; n = p; end
      default: begin e = p; n = p; end
    endcase
    xar[r.ptr] = n;
    cv.v  = 1;
    cv.ad = c ? ((e & 'h7F_0000) + m_bsa[r.ptr[2:1]] + (e & 'hFFFF)) & MASK
              : e;
    cv.bt = (r.acc == aig_pkg::AIG_ACC_BIT);
    cv.bn = e & 'h3F;
    cv.er = cv.bt && (e & 'hFFFF) > (m_tw ? 39 : 15);
  endtask

  // ******************************************
  // random traffic, checked every cycle
  // ******************************************
  initial begin
    aig_pkg::aig_req_s  r;
    aig_pkg::aig_load_s l;
    int k, s, erd;
    failures = 0;
    n_compared = 0;
    reset_n = 1'b0;
    {sel, leg, legal, twide, t0, rd_sel} = '0;
    bsa = '{default: 16'h0000};
    xar = '{default: 0};
    pv = '{default: 0};
    void'($urandom(92));
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6000; i++) begin
      @(posedge mclk);
      s = $urandom % 8;
      erd = xar[s];
      rd_sel <= 3'(s);
      cv = pv;
      {cv.v, cv.rf, cv.er} = '0;
      m_sel = ($urandom % 4) == 0;
      m_leg = $urandom % 2;
      m_legal = ($urandom % 8) != 0;
      m_tw = $urandom % 2;
      m_t0 = int'($signed(16'($urandom)));
      foreach (m_bsa[j]) m_bsa[j] = $urandom % 'h1_0000;
      foreach (bsa[j]) bsa[j] <= 16'(m_bsa[j]);
      {sel, leg, legal, twide} <= 4'({m_sel[0], m_leg[0], m_legal[0], m_tw[0]});
      t0 <= 16'(m_t0);
      k = $urandom % 3;
      r = aig_pkg::aig_req_s'(9'($urandom));
      r.acc = aig_pkg::aig_acc_e'($urandom % 3);
      if (r.acc == aig_pkg::AIG_ACC_BIT) r.op = aig_pkg::aig_op_e'($urandom % 5);
      if (r.op >= aig_pkg::AIG_OP_POST_ADD) r.ptr[2] = 1'b0;
      l = aig_pkg::aig_load_s'(27'({$urandom, $urandom}));
      // low ends near page edges and bit limits half the time
      if ($urandom % 2) l.data[15:0] = 16'($urandom % 48) - 16'h0004;
      if (l.ptr[2:1] == 2'b10) l.data[15:6] = '0;
      l = u_dec.legal(l);
      if (k == 2) xar[l.ptr] = l.full ? int'(l.data)
                             : (xar[l.ptr] & 'h7F_0000) | int'(l.data[15:0]);
      if (k == 1) model(r);
      u_dec.drive(k, r, l);
      @(negedge mclk);
      chk_val("rd_ptr", rd_ptr, erd);
      chk_flag("out_valid", out_valid, pv.v);
      chk_flag("out_refused", out_refused, pv.rf);
      chk_val("out_addr", out_addr, pv.ad);
      chk_val("out_io_addr", 23'(out_io_addr), pv.ad & 'hFFFF);
      if (pv.v && pv.bt) chk_val("out_bit_num", 23'(out_bit_num), pv.bn);
      chk_flag("out_bit_range_err", out_bit_range_err, pv.er);
      pv = cv;
    end
    // reset in mid-run clears the pointer file and outputs
    @(posedge mclk);
    u_dec.drive(0, r, l);
    reset_n <= 1'b0;
    @(negedge mclk);
    chk_val("rd_ptr", rd_ptr, 0);
    chk_val("out_addr", out_addr, 0);
    repeat (2) @(posedge mclk);
    // release, then post-increment pointer 0 at the first edge after
    reset_n <= 1'b1;
    sel <= 1'b0;
    rd_sel <= 3'h0;
    r = '0;
    r.op = aig_pkg::AIG_OP_POST_INC;
    u_dec.drive(1, r, l);
    @(negedge mclk);
    chk_flag("out_valid", out_valid, 0);
    chk_val("rd_ptr", rd_ptr, 0);
    @(posedge mclk);
    u_dec.drive(0, r, l);
    @(negedge mclk);
    chk_flag("out_valid", out_valid, 1);
    chk_val("out_addr", out_addr, 0);
    chk_val("rd_ptr", rd_ptr, 1);
    wrap_up();
  end
endmodule
`default_nettype wire
